// File: hdl/accr_pkg.sv
// Constants, field layout and carrier types for the converter channel configuration block.
// Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port.
package accr_pkg;

    // Register byte addresses
    localparam logic [31:0] CURR_CTRL_ADDR = 32'hffff050c;
    localparam logic [31:0] VOLT_CTRL_ADDR = 32'hffff0510;
    localparam logic [31:0] TEMP_CTRL_ADDR = 32'hffff0514;
    localparam logic [31:0] FILT_CTRL_ADDR = 32'hffff0518;
    localparam logic [31:0] STATUS_ADDR = 32'hffff0530;

    // Values after reset
    localparam logic [15:0] CURR_CTRL_RST = 16'h0002;
    localparam logic [15:0] VOLT_CTRL_RST = 16'h0000;
    localparam logic [15:0] TEMP_CTRL_RST = 16'h0000;
    localparam logic [15:0] FILT_CTRL_RST = 16'h0007;

    // Bits that hold state; the rest read as zero
    localparam logic [15:0] CURR_CTRL_MASK = 16'he2ff;
    localparam logic [15:0] VOLT_CTRL_MASK = 16'h82f0;
    localparam logic [15:0] TEMP_CTRL_MASK = 16'he2f0;
    localparam logic [15:0] FILT_CTRL_MASK = 16'hffff;

    // Field positions
    localparam int unsigned EN_BIT = 15;
    localparam int unsigned ISRC_LO = 13;
    localparam int unsigned CODING_BIT = 9;
    localparam int unsigned INSEL_LO = 6;
    localparam int unsigned REFSEL_LO = 4;

    // Status register layout
    localparam int unsigned STAT_SETTLING_BIT = 0;
    localparam int unsigned STAT_RESULT_OK_BIT = 1;
    localparam int unsigned STAT_ENABLES_LO = 2;

    // Field codes
    localparam logic [1:0] INSEL_INT_SENSOR = 2'h0;
    localparam logic [3:0] VOLT_INSEL_VALID = 4'h9;
    localparam logic [5:0] CODES_PER_K_TWOS = 6'h10;
    localparam logic [5:0] CODES_PER_K_UNI = 6'h20;

    // Converter reset vector value that resets all converters
    localparam logic [2:0] CONV_ALL = 3'h7;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Settling time per enabled converter
    localparam int unsigned SETTLE_TIME_US = 60;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_CNT_W = 16;

    typedef enum logic [1:0] {
        ACCR_IDLE = 2'b00,
        ACCR_SETTLE = 2'b01,
        ACCR_READY = 2'b11
    } accr_settle_state_t;

    typedef struct packed {
        logic powered;
        logic unipolar;
        logic [3:0] input_onehot;
        logic [3:0] ref_onehot;
        logic [1:0] isrc;
        logic [5:0] codes_per_k;
    } accr_chan_out_t;

    function automatic logic [3:0] sel_onehot(input logic [1:0] sel);
        sel_onehot = 4'h1 << sel;
    endfunction

endpackage

// File: hdl/accr_chan_decode.sv
// Decodes one channel control word into registered analogue steering signals.
// Assumes the control word comes from a flip-flop in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module accr_chan_decode
    import accr_pkg::*;
#(
    parameter bit IS_TEMP = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [15:0] ctrl,
    output var accr_chan_out_t cfg
);

    accr_chan_out_t cfg_nxt;

    always_comb begin
        cfg_nxt = '0;
        cfg_nxt.powered = ctrl[EN_BIT];
        cfg_nxt.unipolar = ctrl[CODING_BIT];
        // Undefined voltage input codes select nothing
        cfg_nxt.input_onehot = sel_onehot(ctrl[INSEL_LO +: 2]) & (IS_TEMP ? 4'hf : VOLT_INSEL_VALID);
        cfg_nxt.ref_onehot = sel_onehot(ctrl[REFSEL_LO +: 2]);
        if (IS_TEMP) begin
            cfg_nxt.isrc = ctrl[ISRC_LO +: 2];
            if (ctrl[INSEL_LO +: 2] == INSEL_INT_SENSOR) begin
                cfg_nxt.codes_per_k = ctrl[CODING_BIT] ? CODES_PER_K_UNI : CODES_PER_K_TWOS;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg <= '0;
        end else begin
            cfg <= cfg_nxt;
        end
    end

    a_undef_input_none: assert property (
        @(posedge ref_clk) disable iff (rst)
        !IS_TEMP |-> cfg.input_onehot[2:1] == 2'b00)
        else $error("undefined voltage input code routed");

    a_ref_ext_pick: assert property (
        @(posedge ref_clk) disable iff (rst)
        ctrl[REFSEL_LO +: 2] == 2'b01 |=> cfg.ref_onehot == 4'b0010)
        else $error("external reference not selected");

    a_isrc_both_on: assert property (
        @(posedge ref_clk) disable iff (rst)
        IS_TEMP && ctrl[14:13] == 2'b11 |=> cfg.isrc == 2'b11)
        else $error("both current sources not enabled");

    a_sensor_scale_uni: assert property (
        @(posedge ref_clk) disable iff (rst)
        IS_TEMP && ctrl[7:6] == 2'b00 && ctrl[9] |=> cfg.codes_per_k == 6'd32 && cfg.unipolar)
        else $error("unipolar sensor scale wrong");

endmodule
`default_nettype wire

// File: hdl/accr_settle_timer.sv
// Holds off the first conversion result after a converter reset.
// Assumes the reset pulse and enables are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module accr_settle_timer
    import accr_pkg::*;
#(
    parameter int unsigned CYCLES_PER_CONV = SETTLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic conv_reset,
    input wire logic [2:0] enables,
    output logic settling,
    output logic result_ok
);

    accr_settle_state_t state_r;
    logic [SETTLE_CNT_W-1:0] cnt_r;
    logic [SETTLE_CNT_W-1:0] load_nxt;

    // Extra wait is per enabled converter
    always_comb begin
        load_nxt = SETTLE_CNT_W'((32'(enables[0]) + 32'(enables[1]) + 32'(enables[2])) * CYCLES_PER_CONV);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_r <= ACCR_IDLE;
            cnt_r <= '0;
        end else if (conv_reset) begin
            cnt_r <= load_nxt;
            state_r <= (load_nxt == '0) ? ACCR_READY : ACCR_SETTLE;
        end else begin
            case (state_r)
                ACCR_SETTLE: begin
                    cnt_r <= cnt_r - SETTLE_CNT_W'(1);
                    if (cnt_r == SETTLE_CNT_W'(1)) begin
                        state_r <= ACCR_READY;
                    end
                end
                default: begin
                    cnt_r <= '0;
                end
            endcase
        end
    end

    assign settling = (state_r == ACCR_SETTLE);
    assign result_ok = (state_r != ACCR_SETTLE);

    sequence s_reset_all_on;
        conv_reset && enables == 3'b111;
    endsequence

    a_settle_holds_off: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_reset_all_on |=> !result_ok [*3])
        else $error("result released too early");

    a_settle_ends_count: assert property (
        @(posedge ref_clk) disable iff (rst)
        state_r == ACCR_SETTLE && cnt_r == SETTLE_CNT_W'(1) && !conv_reset |=> result_ok)
        else $error("settling did not end");

endmodule
`default_nettype wire

// File: hdl/accr_top.sv
// Configuration registers for the voltage and temperature converter channels, with filter
// and current channel words, converter reset and settle hold-off, behind an AXI4-Lite slave.
// Assumes all bus inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module accr_top
    import accr_pkg::*;
#(
    parameter int unsigned CYCLES_PER_CONV = SETTLE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output var accr_chan_out_t volt_cfg,
    output var accr_chan_out_t temp_cfg,
    output logic [15:0] curr_ctrl,
    output logic [15:0] filt_ctrl,
    output logic [2:0] conv_reset,
    output logic settling,
    output logic result_ok
);

    logic aw_have_r;
    logic w_have_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_exec;
    logic [15:0] curr_r;
    logic [15:0] volt_r;
    logic [15:0] temp_r;
    logic [15:0] filt_r;
    logic [15:0] curr_nxt;
    logic [15:0] volt_nxt;
    logic [15:0] temp_nxt;
    logic [15:0] filt_nxt;
    logic hit_curr;
    logic hit_volt;
    logic hit_temp;
    logic hit_filt;
    logic [2:0] conv_reset_r;
    logic [2:0] conv_reset_nxt;
    logic [31:0] rd_word;
    logic rd_hit;

    function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] reg_addr);
        addr_hit = (addr[31:2] == reg_addr[31:2]);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] tmp;
        tmp = old;
        if (strb[0]) begin
            tmp[7:0] = data[7:0];
        end
        if (strb[1]) begin
            tmp[15:8] = data[15:8];
        end
        merge = tmp & mask;
    endfunction

    // Write channel: address and data taken in either order
    assign s_axi_awready = !aw_have_r;
    assign s_axi_wready = !w_have_r;
    assign wr_exec = aw_have_r && w_have_r && !bvalid_r;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_have_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_exec) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w_have_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_exec) begin
            w_have_r <= 1'b0;
        end
    end

    always_comb begin
        hit_curr = addr_hit(awaddr_r, CURR_CTRL_ADDR);
        hit_volt = addr_hit(awaddr_r, VOLT_CTRL_ADDR);
        hit_temp = addr_hit(awaddr_r, TEMP_CTRL_ADDR);
        hit_filt = addr_hit(awaddr_r, FILT_CTRL_ADDR);
        curr_nxt = merge(curr_r, wdata_r, wstrb_r, CURR_CTRL_MASK);
        volt_nxt = merge(volt_r, wdata_r, wstrb_r, VOLT_CTRL_MASK);
        temp_nxt = merge(temp_r, wdata_r, wstrb_r, TEMP_CTRL_MASK);
        filt_nxt = merge(filt_r, wdata_r, wstrb_r, FILT_CTRL_MASK);
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_exec) begin
            bvalid_r <= 1'b1;
            bresp_r <= (hit_curr || hit_volt || hit_temp || hit_filt || addr_hit(awaddr_r, STATUS_ADDR)) ?
                       RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Control words
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            volt_r <= VOLT_CTRL_RST;
        end else if (wr_exec && hit_volt) begin
            volt_r <= volt_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            temp_r <= TEMP_CTRL_RST;
        end else if (wr_exec && hit_temp) begin
            temp_r <= temp_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            curr_r <= CURR_CTRL_RST;
        end else if (wr_exec && hit_curr) begin
            curr_r <= curr_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            filt_r <= FILT_CTRL_RST;
        end else if (wr_exec && hit_filt) begin
            filt_r <= filt_nxt;
        end
    end

    // Converter resets on a changed filter or current word
    always_comb begin
        conv_reset_nxt = 3'b000;
        if (wr_exec && hit_filt && filt_nxt != filt_r) begin
            conv_reset_nxt = CONV_ALL;
        end
        if (wr_exec && hit_curr && curr_nxt != curr_r) begin
            conv_reset_nxt = CONV_ALL;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            conv_reset_r <= 3'b000;
        end else begin
            conv_reset_r <= conv_reset_nxt;
        end
    end

    assign conv_reset = conv_reset_r;
    assign curr_ctrl = curr_r;
    assign filt_ctrl = filt_r;

    accr_chan_decode #(
        .IS_TEMP(1'b0)
    ) u_volt_dec (
        .ref_clk(ref_clk),
        .rst(rst),
        .ctrl(volt_r),
        .cfg(volt_cfg)
    );

    accr_chan_decode #(
        .IS_TEMP(1'b1)
    ) u_temp_dec (
        .ref_clk(ref_clk),
        .rst(rst),
        .ctrl(temp_r),
        .cfg(temp_cfg)
    );

    accr_settle_timer #(
        .CYCLES_PER_CONV(CYCLES_PER_CONV)
    ) u_settle (
        .ref_clk(ref_clk),
        .rst(rst),
        .conv_reset(|conv_reset_r),
        .enables({temp_r[EN_BIT], volt_r[EN_BIT], curr_r[EN_BIT]}),
        .settling(settling),
        .result_ok(result_ok)
    );

    // Read channel
    assign s_axi_arready = !rvalid_r;

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        if (addr_hit(s_axi_araddr, CURR_CTRL_ADDR)) begin
            rd_word[15:0] = curr_r;
        end else if (addr_hit(s_axi_araddr, VOLT_CTRL_ADDR)) begin
            rd_word[15:0] = volt_r;
        end else if (addr_hit(s_axi_araddr, TEMP_CTRL_ADDR)) begin
            rd_word[15:0] = temp_r;
        end else if (addr_hit(s_axi_araddr, FILT_CTRL_ADDR)) begin
            rd_word[15:0] = filt_r;
        end else if (addr_hit(s_axi_araddr, STATUS_ADDR)) begin
            rd_word[STAT_SETTLING_BIT] = settling;
            rd_word[STAT_RESULT_OK_BIT] = result_ok;
            rd_word[STAT_ENABLES_LO +: 3] = {temp_r[EN_BIT], volt_r[EN_BIT], curr_r[EN_BIT]};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    sequence s_volt_on_write;
        wr_exec && hit_volt && wstrb_r[1] && wdata_r[15];
    endsequence

    sequence s_volt_uni_write;
        wr_exec && hit_volt && wstrb_r[1] && wdata_r[9];
    endsequence

    a_volt_power_on: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_volt_on_write |=> volt_r[15] ##1 volt_cfg.powered)
        else $error("voltage converter not powered after enable write");

    a_volt_coding_uni: assert property (
        @(posedge ref_clk) disable iff (rst)
        s_volt_uni_write |-> ##2 volt_cfg.unipolar)
        else $error("voltage coding not unipolar");

    a_filter_change_reset: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_exec && hit_filt && filt_nxt != filt_r |=> conv_reset == 3'b111 ##1 conv_reset == 3'b000 || $past(wr_exec))
        else $error("filter change did not reset converters");

    a_curr_change_reset: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_exec && hit_curr && curr_nxt != curr_r |=> conv_reset[2:1] == 2'b11)
        else $error("current word change did not reset other converters");

    a_write_one_resp: assert property (
        @(posedge ref_clk) disable iff (rst)
        wr_exec |=> s_axi_bvalid && !aw_have_r && !w_have_r)
        else $error("write response missing");

    a_reserved_read_zero: assert property (
        @(posedge ref_clk) disable iff (rst)
        (volt_r & ~VOLT_CTRL_MASK) == 16'h0000 && (temp_r & ~TEMP_CTRL_MASK) == 16'h0000)
        else $error("reserved bits hold state");

endmodule
`default_nettype wire

// File: test/accr_top_tb_top.sv
// Self-checking bench for the converter channel configuration registers.
// Assumes accr_pkg and accr_top are compiled first; runs the settle count at 8 cycles per enabled converter.
`timescale 1ns/1ps
`default_nettype none
module accr_top_tb_top;
    import accr_pkg::*;
    localparam int unsigned CPC = 8;
    localparam logic [31:0] BAD_ADDR = 32'hffff0520;
    logic ref_clk, rst;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [2:0] s_axi_awprot, s_axi_arprot, conv_reset;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, settling, result_ok;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    accr_chan_out_t volt_cfg, temp_cfg;
    logic [15:0] curr_ctrl, filt_ctrl;
    logic [15:0] sh[4];
    logic [15:0] msk[4];
    logic [31:0] addrs[4];
    int miscompares, samples_checked, cycles, pulses, run, seed;

    accr_top #(.CYCLES_PER_CONV(CPC)) DUT (
        .ref_clk(ref_clk), .rst(rst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(s_axi_arprot), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .volt_cfg(volt_cfg), .temp_cfg(temp_cfg), .curr_ctrl(curr_ctrl),
        .filt_ctrl(filt_ctrl), .conv_reset(conv_reset), .settling(settling), .result_ok(result_ok)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_cfg(input string what, input accr_chan_out_t exp, input accr_chan_out_t got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Expected decode of one channel word
    function automatic accr_chan_out_t exp_cfg(input logic [15:0] w, input bit is_temp);
        accr_chan_out_t c;
        c = '0;
        c.powered = w[15];
        c.unipolar = w[9];
        c.ref_onehot = 4'h1 << w[5:4];
        if (is_temp) begin
            c.input_onehot = 4'h1 << w[7:6];
            c.isrc = w[14:13];
            if (w[7:6] == 2'h0) c.codes_per_k = w[9] ? 6'h20 : 6'h10;
        end else begin
            c.input_onehot = (w[7:6] == 2'h0) ? 4'h1 : ((w[7:6] == 2'h3) ? 4'h8 : 4'h0);
        end
        return c;
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] o, d, input logic [3:0] st, input logic [15:0] m);
        logic [15:0] bm;
        bm = {{8{st[1]}}, {8{st[0]}}};
        return ((o & ~bm) | (d & bm)) & m;
    endfunction

    task automatic axi_wr(input logic [31:0] a, input logic [15:0] d, input logic [3:0] st, output logic [1:0] r);
        logic aw_hs, w_hs, b_hs;
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge ref_clk);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            b_hs = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end while (b_hs !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_hs, r_hs;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge ref_clk);
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end while (r_hs !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic check_cfg();
        cmp_cfg("volt_cfg", exp_cfg(sh[1], 1'b0), volt_cfg);
        cmp_cfg("temp_cfg", exp_cfg(sh[2], 1'b1), temp_cfg);
        cmp("curr_ctrl", {16'h0, sh[0]}, {16'h0, curr_ctrl});
        cmp("filt_ctrl", {16'h0, sh[3]}, {16'h0, filt_ctrl});
    endtask

    // Write, then check pulse, readback and decode, plus settle length after a changed filter word
    task automatic do_write(input int idx, input logic [15:0] d, input logic [3:0] st);
        logic [15:0] nv;
        int p0, n, exp_p;
        nv = merge(sh[idx], d, st, msk[idx]);
        exp_p = ((idx == 0 || idx == 3) && nv != sh[idx]) ? 1 : 0;
        n = sh[0][15] + sh[1][15] + sh[2][15];
        p0 = pulses;
        axi_wr(addrs[idx], d, st, resp);
        cmp("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
        sh[idx] = nv;
        repeat (4) @(posedge ref_clk);
        cmp("reset pulses", exp_p, pulses - p0);
        axi_rd(addrs[idx], rd, resp);
        cmp("readback", {16'h0, nv}, rd);
        check_cfg();
        for (int k = 0; k < 200 && settling !== 1'b0; k++) @(posedge ref_clk);
        @(posedge ref_clk);
        if (idx == 3 && exp_p == 1) cmp("settle cycles", n * CPC, run);
    endtask

    // Pulse and settle monitor, plus timeout
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (!rst && conv_reset !== 3'h0) begin
            pulses <= pulses + 1;
            run <= 0;
            cmp("conv_reset", 32'h7, {29'h0, conv_reset});
        end else if (settling === 1'b1) begin
            run <= run + 1;
        end
        if (!rst) cmp("result_ok", {31'h0, ~settling}, {31'h0, result_ok});
        if (cycles == 20000) begin
            miscompares++;
            $display("[ERR] timeout expected done seen running");
            stop_test();
        end
    end

    initial begin
        seed = 32'h71f9;
        {cycles, pulses, run, miscompares, samples_checked} = '0;
        rst = 1'b1;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        addrs = '{CURR_CTRL_ADDR, VOLT_CTRL_ADDR, TEMP_CTRL_ADDR, FILT_CTRL_ADDR};
        msk = '{CURR_CTRL_MASK, VOLT_CTRL_MASK, TEMP_CTRL_MASK, FILT_CTRL_MASK};
        sh = '{CURR_CTRL_RST, 16'h0000, 16'h0000, 16'h0007};
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            axi_rd(addrs[i], rd, resp);
            cmp("reset value", {16'h0, sh[i]}, rd);
        end
        check_cfg();
        // Unmapped place
        axi_wr(BAD_ADDR, 16'hffff, 4'hf, resp);
        cmp("bresp unmapped", {30'h0, RESP_DECERR}, {30'h0, resp});
        axi_rd(BAD_ADDR, rd, resp);
        cmp("rresp unmapped", {30'h0, RESP_DECERR}, {30'h0, resp});
        cmp("rdata unmapped", 32'h0, rd);
        // Identical filter rewrite resets nothing
        do_write(3, 16'h0007, 4'hf);
        // Settle length with zero to three converters enabled
        for (int n = 0; n < 4; n++) begin
            do_write(0, {n > 0, 15'h0}, 4'h2);
            // Attenuator toggle belongs to software outside this block
            do_write(1, {n > 1, 15'h0}, 4'h3);
            do_write(2, {n > 2, 15'h0}, 4'h3);
            do_write(3, sh[3] ^ 16'h0100, 4'h3);
        end
        // Random words, lanes and registers
        for (int i = 0; i < 48; i++) begin
            int ri;
            logic [15:0] rw;
            ri = $unsigned($random(seed)) % 4;
            rw = 16'($random(seed));
            // Software keeps reserved channel bits at zero
            if (ri == 1 || ri == 2) rw = rw & msk[ri];
            do_write(ri, rw, 4'($random(seed)));
        end
        stop_test();
    end
endmodule
`default_nettype wire
